// [src/fua_regs.vh]
`ifndef FUA_REGS_VH
`define FUA_REGS_VH

// Register byte offsets (word aligned)
`define FUA_ADDR_BUF_LO      8'h00
`define FUA_ADDR_BUF_HI      8'h04
`define FUA_ADDR_RES_ADDR    8'h08
`define FUA_ADDR_RES_OFFSET  8'h0c
`define FUA_ADDR_CTRL        8'h10
`define FUA_ADDR_STATUS      8'h14
`define FUA_ADDR_FILE_INFO   8'h18
`define FUA_ADDR_ACCESS_LVL  8'h1c
`define FUA_ADDR_NV_FREE     8'h20
`define FUA_ADDR_IRQ_STATUS  8'h24
`define FUA_ADDR_IRQ_MASK    8'h28

// Control register fields
`define FUA_CTRL_START_BIT   0
`define FUA_CTRL_WRITE_BIT   1
`define FUA_CTRL_LEN_LSB     4
`define FUA_CTRL_LEN_MSB     7

// Status register fields
`define FUA_STAT_RELEASE_BIT 0
`define FUA_STAT_ERROR_BIT   1
`define FUA_STAT_BUSY_BIT    2

// Interrupt status fields
`define FUA_IRQ_DONE_BIT     0
`define FUA_IRQ_ERR_BIT      1

// Resource identifiers
`define FUA_RID_FILE_DATA    10'h131
`define FUA_RID_FILE_STATUS  10'h132

// Accepted long message lengths
`define FUA_LEN_2            4'h2
`define FUA_LEN_4            4'h4
`define FUA_LEN_8            4'h8

// Rights codes and file limit
`define FUA_RIGHT_FORBIDDEN  4'hf
`define FUA_FILE_MAX         17'h08000

// Error codes
`define FUA_ERR_NV_FULL      16'h4314
`define FUA_ERR_NOT_LOADED   16'h4310
`define FUA_ERR_DENIED       16'h4311
`define FUA_ERR_RANGE        16'h4312
`define FUA_ERR_LENGTH       16'h4313
`define FUA_ERR_UNKNOWN_RID  16'h4316
`define FUA_ERR_READ_ONLY    16'h4317

// Reset values
`define FUA_RST_NV_FREE      16'h8000
`define FUA_RST_IRQ_MASK     2'h0

`endif

// [src/fua_file_access.v]
`timescale 1ns/1ps
`default_nettype none
`include "fua_regs.vh"

// How it works
// - File data resource answers on identifier 131h and moves up to 8 bytes per message, bounded by file length for reads and by the file limit for writes.
// - File data resource itself needs level 0; the loaded file's own rights decide read or write permission.
// - Nothing is read or written unless a file is loaded, and only the loaded file is touched.
// - A read that would run past the file size gives an error and no data.
// - A write that runs past the file size grows the file to hold the new bytes.
// - A write starting above the file size is refused.
// - If free non-volatile space cannot hold the growth, the write is aborted with code 4314h.
// - Only lengths 2, 4 and 8 bytes are accepted for file data; the status resource does not check the length.
// - Read and write data live in long message buffer bytes 7 down to 0.
// - Offsets run 0 to 32767 and no file may exceed 32768 bytes.
// - File status resource answers on 132h with 4 bytes, read level 0, write level 15, so read only.
// - Status reports the file loaded at that moment.
// - Status bytes 3 and 2 hold the file size (byte 3 low, byte 2 high), byte 1 reserved.
// - Status byte 0 bits 7 to 4 hold the write right code, 15 meaning forbidden.
// - Status byte 0 bits 3 to 0 hold the read right code, 15 meaning forbidden.
module fua_file_access (
  input wire CLK,
  input wire RESET,
  input wire CE,
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  output wire IRQ
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CHECK = 2'h1;
  localparam [1:0] ST_XFER = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  // Registers
  reg ack_q;
  reg [63:0] buf_q;
  reg [7:0] res_addr_high_q;
  reg [7:0] res_addr_low_q;
  reg [7:0] res_off_high_q;
  reg [7:0] res_off_low_q;
  reg ctrl_write_q;
  reg [3:0] ctrl_len_q;
  reg release_q;
  reg error_q;
  reg [15:0] err_code_q;
  reg loaded_q;
  reg [3:0] write_right_q;
  reg [3:0] read_right_q;
  reg [15:0] file_size_q;
  reg [3:0] access_level_q;
  reg [15:0] nv_free_q;
  reg [1:0] irq_status_q;
  reg [1:0] irq_mask_q;
  reg [1:0] state_q;
  reg [3:0] idx_q;
  reg [3:0] len_q;
  reg dir_write_q;

  // File contents of the loaded file
  reg [7:0] file_mem [0:32767];

  reg [31:0] rd_mux;
  reg [15:0] chk_code;
  reg chk_err;

  wire [31:0] be_mask;
  wire wr_fire;
  wire start;
  wire busy;
  wire [9:0] resource_identifier;
  wire [14:0] offset;
  wire [16:0] end_addr;
  wire [16:0] size_ext;
  wire [16:0] grow;
  wire [14:0] mem_addr;
  wire [7:0] mem_rdata;
  wire len_ok;
  wire [31:0] merged;
  wire read_denied;
  wire write_denied;
  wire read_past_end;
  wire write_gap;
  wire over_limit;
  wire nv_short;
  wire [3:0] start_len;
  wire start_write;

  // Avalon handshake: one wait state, request taken when waitrequest is low
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
  assign wr_fire = CE & AVS_WRITE & ack_q;
  assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign busy = (state_q != ST_IDLE);
  assign start = wr_fire & (AVS_ADDRESS == `FUA_ADDR_CTRL) & AVS_BYTEENABLE[0]
                 & AVS_WRITEDATA[`FUA_CTRL_START_BIT] & ~busy;
  assign IRQ = |(irq_status_q & irq_mask_q);

  // Decode of the latched request
  assign resource_identifier = {res_addr_high_q[1:0], res_addr_low_q};
  assign offset = {res_off_high_q[6:0], res_off_low_q};
  assign size_ext = {1'b0, file_size_q};
  assign end_addr = {2'h0, offset} + {13'h0000, len_q};
  assign grow = (end_addr > size_ext) ? (end_addr - size_ext) : 17'h00000;
  assign len_ok = (len_q == `FUA_LEN_2) | (len_q == `FUA_LEN_4)
                  | (len_q == `FUA_LEN_8);
  assign mem_addr = offset + {11'h000, idx_q};
  assign mem_rdata = file_mem[mem_addr];

  // Rights of the loaded file against the current access level
  assign read_denied = (read_right_q == `FUA_RIGHT_FORBIDDEN)
                       | (read_right_q > access_level_q);
  assign write_denied = (write_right_q == `FUA_RIGHT_FORBIDDEN)
                        | (write_right_q > access_level_q);

  // Address checks; a write may start at the end but not beyond it
  assign read_past_end = (end_addr > size_ext);
  assign write_gap = ({2'h0, offset} > size_ext);
  assign over_limit = (end_addr > `FUA_FILE_MAX);
  assign nv_short = (grow > {1'b0, nv_free_q});

  // Length and direction taken from the start write itself, not the old register
  assign start_len = merged[`FUA_CTRL_LEN_MSB:`FUA_CTRL_LEN_LSB];
  assign start_write = merged[`FUA_CTRL_WRITE_BIT];

  // Byte-enable merge of write data into a register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // Admission checks, first failing check wins
  always @* begin
    chk_err = 1'b1;
    chk_code = 16'h0000;
    if (!loaded_q) begin
      chk_code = `FUA_ERR_NOT_LOADED;
    end else if (resource_identifier == `FUA_RID_FILE_STATUS) begin
      if (dir_write_q) begin
        chk_code = `FUA_ERR_READ_ONLY;
      end else begin
        chk_err = 1'b0;
      end
    end else if (resource_identifier != `FUA_RID_FILE_DATA) begin
      chk_code = `FUA_ERR_UNKNOWN_RID;
    end else if (!len_ok) begin
      chk_code = `FUA_ERR_LENGTH;
    end else if (!dir_write_q) begin
      if (read_denied) begin
        chk_code = `FUA_ERR_DENIED;
      end else if (read_past_end) begin
        chk_code = `FUA_ERR_RANGE;
      end else begin
        chk_err = 1'b0;
      end
    end else begin
      if (write_denied) begin
        chk_code = `FUA_ERR_DENIED;
      end else if (write_gap) begin
        chk_code = `FUA_ERR_RANGE;
      end else if (over_limit) begin
        chk_code = `FUA_ERR_RANGE;
      end else if (nv_short) begin
        chk_code = `FUA_ERR_NV_FULL;
      end else begin
        chk_err = 1'b0;
      end
    end
  end

  // Register read multiplexer, unmapped reads as zero
  always @* begin
    case (AVS_ADDRESS)
      `FUA_ADDR_BUF_LO: rd_mux = buf_q[31:0];
      `FUA_ADDR_BUF_HI: rd_mux = buf_q[63:32];
      `FUA_ADDR_RES_ADDR: rd_mux = {16'h0000, res_addr_high_q, res_addr_low_q};
      `FUA_ADDR_RES_OFFSET: rd_mux = {16'h0000, res_off_high_q, res_off_low_q};
      `FUA_ADDR_CTRL: rd_mux = {24'h000000, ctrl_len_q, 2'h0, ctrl_write_q, 1'b0};
      `FUA_ADDR_STATUS: rd_mux = {err_code_q, 13'h0000, busy, error_q, release_q};
      `FUA_ADDR_FILE_INFO: rd_mux = {file_size_q, write_right_q, read_right_q,
                                     7'h00, loaded_q};
      `FUA_ADDR_ACCESS_LVL: rd_mux = {28'h0000000, access_level_q};
      `FUA_ADDR_NV_FREE: rd_mux = {16'h0000, nv_free_q};
      `FUA_ADDR_IRQ_STATUS: rd_mux = {30'h00000000, irq_status_q};
      `FUA_ADDR_IRQ_MASK: rd_mux = {30'h00000000, irq_mask_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  assign merged = merge(rd_mux, AVS_WRITEDATA, be_mask);

  // Bus acknowledge and registered read data
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ack_q <= 1'b0;
      AVS_READDATA <= 32'h00000000;
    end else if (CE) begin
      ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
      if (AVS_READ & ~ack_q) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

  // Software-set configuration registers
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      res_addr_high_q <= 8'h00;
      res_addr_low_q <= 8'h00;
      res_off_high_q <= 8'h00;
      res_off_low_q <= 8'h00;
      ctrl_write_q <= 1'b0;
      ctrl_len_q <= 4'h0;
      access_level_q <= 4'h0;
      irq_mask_q <= `FUA_RST_IRQ_MASK;
    end else if (CE && wr_fire && !busy) begin
      case (AVS_ADDRESS)
        `FUA_ADDR_RES_ADDR: begin
          res_addr_high_q <= merged[15:8];
          res_addr_low_q <= merged[7:0];
        end
        `FUA_ADDR_RES_OFFSET: begin
          res_off_high_q <= merged[15:8];
          res_off_low_q <= merged[7:0];
        end
        `FUA_ADDR_CTRL: begin
          ctrl_write_q <= merged[`FUA_CTRL_WRITE_BIT];
          ctrl_len_q <= merged[`FUA_CTRL_LEN_MSB:`FUA_CTRL_LEN_LSB];
        end
        `FUA_ADDR_ACCESS_LVL: access_level_q <= merged[3:0];
        `FUA_ADDR_IRQ_MASK: irq_mask_q <= merged[1:0];
        default: ;
      endcase
    end
  end

  // Transaction engine, buffer, file status and free space count
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      idx_q <= 4'h0;
      len_q <= 4'h0;
      dir_write_q <= 1'b0;
      buf_q <= 64'h0000000000000000;
      loaded_q <= 1'b0;
      write_right_q <= 4'h0;
      read_right_q <= 4'h0;
      file_size_q <= 16'h0000;
      nv_free_q <= `FUA_RST_NV_FREE;
    end else if (CE) begin
      // Idle-time software writes; engine owns these while busy
      if (wr_fire && !busy) begin
        case (AVS_ADDRESS)
          `FUA_ADDR_BUF_LO: buf_q[31:0] <= merged;
          `FUA_ADDR_BUF_HI: buf_q[63:32] <= merged;
          `FUA_ADDR_FILE_INFO: begin
            file_size_q <= merged[31:16];
            write_right_q <= merged[15:12];
            read_right_q <= merged[11:8];
            loaded_q <= merged[0];
          end
          `FUA_ADDR_NV_FREE: nv_free_q <= merged[15:0];
          default: ;
        endcase
      end
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            len_q <= start_len;
            dir_write_q <= start_write;
            idx_q <= 4'h0;
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (chk_err) begin
            // Refused: no data moves, straight to release
            state_q <= ST_DONE;
          end else if (resource_identifier == `FUA_RID_FILE_STATUS) begin
            // Status of the file loaded right now
            buf_q <= {32'h00000000, file_size_q[7:0], file_size_q[15:8],
                      8'h00, write_right_q, read_right_q};
            state_q <= ST_DONE;
          end else begin
            state_q <= ST_XFER;
          end
        end
        ST_XFER: begin
          // One byte per cycle between buffer and file
          if (!dir_write_q) begin
            buf_q[idx_q*8 +: 8] <= mem_rdata;
          end
          if (idx_q == len_q - 4'h1) begin
            if (dir_write_q && grow != 17'h00000) begin
              file_size_q <= end_addr[15:0];
              nv_free_q <= nv_free_q - grow[15:0];
            end
            state_q <= ST_DONE;
          end else begin
            idx_q <= idx_q + 4'h1;
          end
        end
        ST_DONE: begin
          // Release flag and events are raised by their own processes
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Completion flags seen by software in the status register
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      release_q <= 1'b0;
      error_q <= 1'b0;
      err_code_q <= 16'h0000;
    end else if (CE) begin
      if (state_q == ST_IDLE && start) begin
        // A new start hides the previous outcome
        release_q <= 1'b0;
        error_q <= 1'b0;
        err_code_q <= 16'h0000;
      end else if (state_q == ST_CHECK && chk_err) begin
        // Refused request: error code, no data moved
        error_q <= 1'b1;
        err_code_q <= chk_code;
      end else if (state_q == ST_DONE) begin
        release_q <= 1'b1;
      end
    end
  end

  // Sticky event flags: write one clears, an event in the same cycle wins
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_status_q <= 2'h0;
    end else if (CE) begin
      if (wr_fire && AVS_ADDRESS == `FUA_ADDR_IRQ_STATUS) begin
        irq_status_q <= irq_status_q & ~merged[1:0];
      end
      // Done on every completion, error only for a refused request
      if (state_q == ST_DONE) begin
        irq_status_q[`FUA_IRQ_DONE_BIT] <= 1'b1;
        if (error_q) begin
          irq_status_q[`FUA_IRQ_ERR_BIT] <= 1'b1;
        end
      end
    end
  end

  // File byte store, written only by admitted write transfers
  always @(posedge CLK) begin
    if (CE && state_q == ST_XFER && dir_write_q) begin
      file_mem[mem_addr] <= buf_q[idx_q*8 +: 8];
    end
  end

endmodule // fua_file_access

`default_nettype wire

// [verif/fua_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module fua_chk (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic IRQ
);
  // Request, answer and status-read views of the bus
  wire logic req = AVS_READ | AVS_WRITE;
  wire logic ack = req & ~AVS_WAITREQUEST;
  wire logic st = ack & AVS_READ & (AVS_ADDRESS == 8'h14);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  chk_wait_first: assert property ($rose(req) |-> AVS_WAITREQUEST)
    else $error("answer without wait state");
  chk_wait_one: assert property (req && AVS_WAITREQUEST && CE |=> !AVS_WAITREQUEST)
    else $error("answer late");
  chk_idle_low: assert property (!req |-> !AVS_WAITREQUEST)
    else $error("wait raised while idle");
  chk_rdata_hold: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data moved");
  chk_unmapped_zero: assert property (st == 1'b0 && ack && AVS_READ && AVS_ADDRESS > 8'h28
    |-> AVS_READDATA == 32'h0) else $error("unmapped read not zero");
  chk_stat_excl: assert property (st |-> !(AVS_READDATA[0] && AVS_READDATA[2]))
    else $error("release while busy");
  chk_err_code: assert property (st && AVS_READDATA[1] |-> AVS_READDATA[31:24] == 8'h43)
    else $error("error without code");
  chk_irq_fall: assert property ($fell(IRQ) |-> $past(AVS_WRITE && !AVS_WAITREQUEST))
    else $error("interrupt dropped without write");
  // Main scenarios reached
  cov_done: cover property (st && AVS_READDATA[0]);
  cov_error: cover property (st && AVS_READDATA[1]);
  cov_irq: cover property ($rose(IRQ));
endmodule // fua_chk
bind fua_file_access fua_chk i_chk (.CLK(CLK), .RESET(RESET), .CE(CE),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ));
`default_nettype wire

// [verif/fua_mst.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fua_regs.vh"
module fua_mst (
  input wire logic clk,
  output var logic [7:0] addr,
  output var logic read,
  output var logic write,
  output var logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic wreq
);
  // Idle bus at time zero
  initial begin
    addr = 8'h0;
    read = 1'b0;
    write = 1'b0;
    wdata = 32'h0;
  end
  // One bus cycle, held until wait is low at a rising edge
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    read <= ~w;
    write <= w;
    // Wait and read data are taken at the rising edge only
    @(posedge clk);
    while (wreq)
      @(posedge clk);
    q = rdata;
    read <= 1'b0;
    write <= 1'b0;
    wdata <= ~d; // Released data does not keep its value
  endtask
  // Long message: resource, offset, start, then poll for release
  task automatic xfer(input logic [9:0] resource_identifier, input logic [14:0] off, input logic [3:0] len,
      input logic w, output logic [31:0] st);
    access(1'b1, `FUA_ADDR_RES_ADDR, {22'h0, resource_identifier}, st);
    access(1'b1, `FUA_ADDR_RES_OFFSET, {17'h0, off}, st);
    access(1'b1, `FUA_ADDR_CTRL, {24'h0, len, 2'h0, w, 1'b1}, st);
    st = 32'h0;
    for (int n = 0; n < 40 && !st[0]; n++)
      access(1'b0, `FUA_ADDR_STATUS, 32'h0, st);
  endtask
endmodule // fua_mst
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [3:0] be = 4'hf;
  logic [7:0] addr;
  logic read;
  logic write;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wreq;
  logic irq;
  logic [31:0] q;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  fua_file_access i_dut (.CLK(clk), .RESET(reset), .CE(ce), .AVS_ADDRESS(addr),
    .AVS_READ(read), .AVS_WRITE(write), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .IRQ(irq));
  fua_mst i_mst (.clk(clk), .addr(addr), .read(read), .write(write), .wdata(wdata),
    .rdata(rdata), .wreq(wreq));
  // 10 MHz clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("BAD t=%0t timeout", $time);
      results();
    end
  end
  // Verdict
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Compare and bus helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic ci(input logic e);
    @(negedge clk);
    cmp({31'h0, irq}, {31'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_mst.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    i_mst.access(1'b0, a, 32'h0, q);
    cmp(q, e);
  endtask
  task automatic run(input logic [9:0] resource_identifier, input logic [14:0] off, input logic [3:0] len,
      input logic w, input logic [15:0] code);
    i_mst.xfer(resource_identifier, off, len, w, q);
    cmp(q, code == 16'h0 ? 32'h1 : {code, 16'h3});
  endtask
  // Reset values, unmapped place, access before load, then load 16 bytes
  task automatic s_reset();
    rd(8'h20, 32'h8000);
    rd(8'h14, 32'h0);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h0);
    run(10'h131, 15'h0, 4'h4, 1'b0, 16'h4310);
    wr(8'h18, 32'h0010_2001);
    wr(8'h1c, 32'h2);
  endtask
  // Status of the loaded file; the status resource refuses writes
  task automatic s_status();
    run(10'h132, 15'h0, 4'h4, 1'b0, 16'h0);
    rd(8'h00, 32'h1000_0020);
    rd(8'h04, 32'h0);
    run(10'h132, 15'h0, 4'h4, 1'b1, 16'h4317);
  endtask
  // Append 8 bytes at the end, then read them back
  task automatic s_grow();
    wr(8'h00, 32'h4433_2211);
    wr(8'h04, 32'h8877_6655);
    run(10'h131, 15'h10, 4'h8, 1'b1, 16'h0);
    rd(8'h20, 32'h7ff8);
    run(10'h132, 15'h0, 4'h4, 1'b0, 16'h0);
    rd(8'h00, 32'h1800_0020);
    run(10'h131, 15'h10, 4'h8, 1'b0, 16'h0);
    rd(8'h00, 32'h4433_2211);
    rd(8'h04, 32'h8877_6655);
  endtask
  // Range edges and message lengths
  task automatic s_range();
    run(10'h131, 15'h16, 4'h4, 1'b0, 16'h4312);
    run(10'h131, 15'h16, 4'h2, 1'b0, 16'h0);
    run(10'h131, 15'h19, 4'h2, 1'b1, 16'h4312);
    run(10'h131, 15'h10, 4'h3, 1'b0, 16'h4313);
    for (int i = 1; i < 4; i++)
      run(10'h131, 15'h10, 4'h1 << i, 1'b0, 16'h0);
  endtask
  // Growth limited by free space: refused, then an exact fit
  task automatic s_nvfull();
    wr(8'h20, 32'h2);
    run(10'h131, 15'h17, 4'h4, 1'b1, 16'h4314);
    rd(8'h18, 32'h0018_2001);
    run(10'h131, 15'h16, 4'h4, 1'b1, 16'h0);
    rd(8'h20, 32'h0);
    rd(8'h18, 32'h001a_2001);
  endtask
  // Largest file size
  task automatic s_limit();
    wr(8'h20, 32'h8000);
    wr(8'h18, 32'h7ffe_2001);
    run(10'h131, 15'h7ffe, 4'h2, 1'b1, 16'h0);
    rd(8'h18, 32'h8000_2001);
    run(10'h131, 15'h7ffe, 4'h4, 1'b1, 16'h4312);
  endtask
  // Per-file rights against the access level
  task automatic s_rights();
    wr(8'h18, 32'h0010_2f01);
    run(10'h131, 15'h0, 4'h2, 1'b0, 16'h4311);
    run(10'h132, 15'h0, 4'h4, 1'b0, 16'h0);
    rd(8'h00, 32'h1000_002f);
    wr(8'h18, 32'h0010_3001);
    run(10'h131, 15'h0, 4'h2, 1'b1, 16'h4311);
    run(10'h131, 15'h0, 4'h2, 1'b0, 16'h0);
  endtask
  // Sticky events, mask and write-one-to-clear
  task automatic s_irq();
    rd(8'h24, 32'h3);
    ci(1'b0);
    wr(8'h28, 32'h2);
    ci(1'b1);
    wr(8'h24, 32'h2);
    ci(1'b0);
    rd(8'h24, 32'h1);
  endtask
  // Clock enable low: a pending bus request waits until it rises again
  task automatic s_freeze();
    int t0;
    t0 = cyc;
    ce <= 1'b0;
    fork
      wr(8'h1c, 32'h3);
      begin
        repeat (4) @(posedge clk);
        ce <= 1'b1;
      end
    join
    cmp({31'h0, (cyc - t0) >= 5}, 32'h1);
    rd(8'h1c, 32'h3);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    s_reset();
    s_status();
    s_grow();
    s_range();
    s_nvfull();
    s_limit();
    s_rights();
    s_irq();
    s_freeze();
    results();
  end
endmodule // testbench
`default_nettype wire
